/* shared/pss_pkg.sv */
package pss_pkg;
  // save key "save" in ascii
  localparam logic [31:0] SAVE_KEY = 32'h65766173;
  localparam logic [31:0] DONE_VAL = 32'h00000001;
  localparam logic [7:0] SUB_ALL = 8'h01;
  localparam logic [7:0] SUB_COMM = 8'h02;
  localparam logic [7:0] SUB_APP = 8'h03;
  localparam logic [7:0] SUB_CUST = 8'h04;
  localparam logic [7:0] SUB_DRIVE = 8'h05;
  localparam logic [7:0] SUB_TUNE = 8'h06;
  localparam logic [7:0] SUB_CAN = 8'h0A;
  localparam logic [7:0] SUB_MODBUS = 8'h0B;
  // category bit positions in the category mask
  localparam int CAT_COMM = 0;
  localparam int CAT_APP = 1;
  localparam int CAT_CUST = 2;
  localparam int CAT_DRIVE = 3;
  localparam int CAT_TUNE = 4;
  localparam int CAT_CAN = 5;
  localparam int CAT_MODBUS = 6;
  localparam int NUM_CAT = 7;
  localparam logic [6:0] MASK_ALL = 7'h0F;
  localparam logic [6:0] MASK_NONE = 7'h00;
  // object index ranges of the communication, drive and tuning groups
  localparam logic [15:0] COMM_PDO_LO = 16'h1400;
  localparam logic [15:0] COMM_PDO_HI = 16'h1A07;
  localparam logic [15:0] DRIVE_LO = 16'h3202;
  localparam logic [15:0] DRIVE_HI = 16'h6080;
  localparam logic [15:0] TUNE_LO = 16'h2030;
  localparam logic [15:0] TUNE_HI = 16'h203B;
  localparam logic [7:0] RESET_SUB = 8'h00;

  typedef struct packed {
    logic [7:0] sub;
    logic [31:0] data;
  } pss_wr_t;

  typedef struct packed {
    logic [15:0] index;
    logic [6:0] cat;
  } pss_obj_t;
endpackage

/* hdl/pss_sequencer.sv */
`timescale 1ns/1ps
// What this block does
// - writing the key 65766173h to a category subindex starts storing every object of that category.
// - when storing ends the triggered subindex is overwritten with 1 as the completion sign.
// - subindex 01h saves every category except tuning, CANopen and Modbus RTU.
// - subindices 02h to 06h, 0Ah and 0Bh each select one single category.
// - a communication save includes the sync, guarding, heartbeat, error and pdo objects 1400h to 1A07h.
// - a drive save includes objects 3202h through 6080h of the drive group.
// - a tuning save includes pole pairs, currents, overload, feedback and encoder resolution objects.
// - objects of no category are never written to storage.
module pss_sequencer #(
  parameter int OBJ_DEPTH = 64
) (
  input wire logic clk,
  input wire logic srst,
  // object write to the save-control object
  input wire logic wrValid,
  input wire pss_pkg::pss_wr_t wrReq,
  // read back of a subindex
  input wire logic [7:0] rdSub,
  output logic [31:0] rdData,
  // object walker: the block scans an object list and stores each member
  output logic [$clog2(OBJ_DEPTH)-1:0] objAddr,
  input wire pss_pkg::pss_obj_t objInfo,
  output logic storeValid,
  output logic [15:0] storeIndex,
  input wire logic storeReady,
  output logic busy
);
  localparam int AW = $clog2(OBJ_DEPTH);
  localparam logic [AW-1:0] LAST = AW'(OBJ_DEPTH - 1);

  typedef enum logic [1:0] {IDLE, FETCH, STORE, FINISH} pss_state_t;

  // ---------------------------------------------
  // subindex value store
  // ---------------------------------------------
  // sixteen slots: only decoded subindices ever write, so the upper sub bits cannot alias a slot
  logic [31:0] subVal [16];
  pss_state_t state;
  logic [7:0] actSub;
  logic [6:0] actMask;

  // ---------------------------------------------
  // decode
  // ---------------------------------------------
  wire isKey = wrReq.data == pss_pkg::SAVE_KEY;
  logic [6:0] wrMask;
  always_comb begin
    unique case (wrReq.sub)
      pss_pkg::SUB_ALL: wrMask = pss_pkg::MASK_ALL;
      pss_pkg::SUB_COMM: wrMask = 7'(1 << pss_pkg::CAT_COMM);
      pss_pkg::SUB_APP: wrMask = 7'(1 << pss_pkg::CAT_APP);
      pss_pkg::SUB_CUST: wrMask = 7'(1 << pss_pkg::CAT_CUST);
      pss_pkg::SUB_DRIVE: wrMask = 7'(1 << pss_pkg::CAT_DRIVE);
      pss_pkg::SUB_TUNE: wrMask = 7'(1 << pss_pkg::CAT_TUNE);
      pss_pkg::SUB_CAN: wrMask = 7'(1 << pss_pkg::CAT_CAN);
      pss_pkg::SUB_MODBUS: wrMask = 7'(1 << pss_pkg::CAT_MODBUS);
      default: wrMask = pss_pkg::MASK_NONE;
    endcase
  end
  wire validSub = wrMask != pss_pkg::MASK_NONE;
  // writes while busy are refused so the running save keeps its subindex
  wire startSave = wrValid && validSub && isKey && state == IDLE;
  wire plainWrite = wrValid && validSub && !isKey && state == IDLE;
  // an object with no category bit never matches, so it is never stored
  wire member = (objInfo.cat & actMask) != pss_pkg::MASK_NONE;
  wire lastObj = objAddr == LAST;

  // ---------------------------------------------
  // sequencer
  // ---------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= IDLE;
      actSub <= pss_pkg::RESET_SUB;
      actMask <= pss_pkg::MASK_NONE;
      objAddr <= '0;
      storeValid <= 1'b0;
      storeIndex <= 16'h0000;
    end else begin
      unique case (state)
        IDLE: begin
          if (startSave) begin
            state <= FETCH;
            actSub <= wrReq.sub;
            actMask <= wrMask;
            objAddr <= '0;
          end
        end
        FETCH: begin
          // one object per cycle: a save lasts at least OBJ_DEPTH cycles, traded for a single compare
          if (member) begin
            state <= STORE;
            storeValid <= 1'b1;
            storeIndex <= objInfo.index;
          end else if (lastObj) begin
            state <= FINISH;
          end else begin
            objAddr <= objAddr + 1'b1;
          end
        end
        STORE: begin
          if (storeReady) begin
            storeValid <= 1'b0;
            if (lastObj) begin
              state <= FINISH;
            end else begin
              state <= FETCH;
              objAddr <= objAddr + 1'b1;
            end
          end
        end
        FINISH: begin
          state <= IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------
  // subindex values and read port
  // ---------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 16; i++) begin
        subVal[i] <= 32'h00000000;
      end
    end else if (state == FINISH) begin
      subVal[actSub[3:0]] <= pss_pkg::DONE_VAL;
    end else if (startSave || plainWrite) begin
      subVal[wrReq.sub[3:0]] <= wrReq.data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdData <= 32'h00000000;
      busy <= 1'b0;
    end else begin
      // one cycle of read latency keeps rdData straight from a flip-flop
      rdData <= subVal[rdSub[3:0]];
      busy <= startSave || (state != IDLE && state != FINISH);
    end
  end

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  a_key_starts: assert property (@(posedge clk) disable iff (srst)
    wrValid && validSub && state == IDLE && isKey |=> state == FETCH)
    else $error("key write did not start a save");
  a_done_one: assert property (@(posedge clk) disable iff (srst)
    state == FINISH |=> subVal[actSub[3:0]] == pss_pkg::DONE_VAL)
    else $error("completion value not written");
  a_all_mask: assert property (@(posedge clk) disable iff (srst)
    startSave && wrReq.sub == pss_pkg::SUB_ALL |=> actMask == pss_pkg::MASK_ALL)
    else $error("subindex one mask wrong");
  a_single_cat: assert property (@(posedge clk) disable iff (srst)
    startSave && wrReq.sub == pss_pkg::SUB_TUNE |=> actMask == 7'h10)
    else $error("tuning subindex mask wrong");
  a_member_only: assert property (@(posedge clk) disable iff (srst)
    $rose(storeValid) |-> (actMask & $past(objInfo.cat)) != 7'h00)
    else $error("non member object stored");
  a_nokey_idle: assert property (@(posedge clk) disable iff (srst)
    wrValid && state == IDLE && !isKey |=> state == IDLE)
    else $error("non key write started a save");
  a_store_held: assert property (@(posedge clk) disable iff (srst)
    storeValid && !storeReady |=> storeValid && $stable(storeIndex))
    else $error("store request dropped");
  a_busy_flag: assert property (@(posedge clk) disable iff (srst)
    state == STORE |-> busy)
    else $error("busy low during store");

  // ---------------------------------------------
  // checks: one category per subindex
  // ---------------------------------------------
  a_comm_mask: assert property (@(posedge clk) disable iff (srst)
    startSave && wrReq.sub == pss_pkg::SUB_COMM |=> actMask == 7'h01)
    else $error("communication subindex mask wrong");
  a_app_mask: assert property (@(posedge clk) disable iff (srst)
    startSave && wrReq.sub == pss_pkg::SUB_APP |=> actMask == 7'h02)
    else $error("application subindex mask wrong");
  a_cust_mask: assert property (@(posedge clk) disable iff (srst)
    startSave && wrReq.sub == pss_pkg::SUB_CUST |=> actMask == 7'h04)
    else $error("customer subindex mask wrong");
  a_drive_mask: assert property (@(posedge clk) disable iff (srst)
    startSave && wrReq.sub == pss_pkg::SUB_DRIVE |=> actMask == 7'h08)
    else $error("drive subindex mask wrong");
  a_can_mask: assert property (@(posedge clk) disable iff (srst)
    startSave && wrReq.sub == pss_pkg::SUB_CAN |=> actMask == 7'h20)
    else $error("canopen subindex mask wrong");
  a_modbus_mask: assert property (@(posedge clk) disable iff (srst)
    startSave && wrReq.sub == pss_pkg::SUB_MODBUS |=> actMask == 7'h40)
    else $error("modbus subindex mask wrong");

  // ---------------------------------------------
  // checks: object walk, completion, refused writes and plain writes
  // ---------------------------------------------
  a_walk_step: assert property (@(posedge clk) disable iff (srst)
    state == FETCH && !member && !lastObj |=> objAddr == $past(objAddr) + 1'b1)
    else $error("non member object not skipped");
  a_finish_last: assert property (@(posedge clk) disable iff (srst)
    state == FINISH |-> objAddr == LAST)
    else $error("save ended before the last object");
  a_store_state: assert property (@(posedge clk) disable iff (srst)
    storeValid |-> state == STORE)
    else $error("store request outside a store step");
  a_done_busy: assert property (@(posedge clk) disable iff (srst)
    state == FINISH |=> !busy)
    else $error("busy still high after completion");
  a_busy_refuse: assert property (@(posedge clk) disable iff (srst)
    wrValid && state != IDLE |=> $stable(actSub))
    else $error("write during a save moved the triggered subindex");
  a_plain_value: assert property (@(posedge clk) disable iff (srst)
    plainWrite |=> subVal[$past(wrReq.sub[3:0])] == $past(wrReq.data))
    else $error("plain write value not kept");

  c_save_all: cover property (@(posedge clk) startSave && wrReq.sub == pss_pkg::SUB_ALL);
  c_save_tune: cover property (@(posedge clk) startSave && wrReq.sub == pss_pkg::SUB_TUNE);
  c_store: cover property (@(posedge clk) storeValid && storeReady);
  c_finish: cover property (@(posedge clk) state == FINISH);
  c_nokey: cover property (@(posedge clk) plainWrite);
endmodule

/* testbench/pss_obj_table.sv */
`timescale 1ns/1ps
module pss_obj_table (
  input wire logic [2:0] objAddr,
  output pss_pkg::pss_obj_t objInfo,
  input wire logic stall,
  output logic storeReady
);
  // one object per saved group, except none for customer and two for communication, plus a live status object that no save may touch
  pss_pkg::pss_obj_t tbl [8] = '{
    {16'h1400, 7'h01},
    {16'h2034, 7'h02},
    {16'h3202, 7'h08},
    {16'h2030, 7'h10},
    {16'h2005, 7'h20},
    {16'h2028, 7'h40},
    {16'h6041, 7'h00},
    {16'h1A07, 7'h01}
  };
  assign objInfo = tbl[objAddr];
  // storage stalls at random so the held request is exercised
  assign storeReady = ~stall;
endmodule

/* testbench/parameter_save_sequencer_bench.sv */
`timescale 1ns/1ps
module parameter_save_sequencer_bench;
  logic clk = 0;
  logic srst = 1;
  logic wrValid = 0;
  logic stall = 0;
  pss_pkg::pss_wr_t wrReq = '0;
  logic [7:0] rdSub = 8'h00;
  logic [31:0] rdData;
  logic [2:0] objAddr;
  pss_pkg::pss_obj_t objInfo;
  logic storeValid, storeReady, busy;
  logic [15:0] storeIndex;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] rs = 32'h0000FD3A;
  logic [15:0] got [$];
  logic [15:0] exp [$];
  logic [7:0] subs [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0A, 8'h0B};
  always #12.5 clk = ~clk;
  pss_sequencer #(.OBJ_DEPTH(8)) pss_sequencer_inst (.clk(clk), .srst(srst), .wrValid(wrValid), .wrReq(wrReq),
    .rdSub(rdSub), .rdData(rdData), .objAddr(objAddr), .objInfo(objInfo), .storeValid(storeValid),
    .storeIndex(storeIndex), .storeReady(storeReady), .busy(busy));
  pss_obj_table pss_obj_table_inst (.objAddr(objAddr), .objInfo(objInfo), .stall(stall), .storeReady(storeReady));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  function automatic logic [6:0] msk(input logic [7:0] s);
    case (s)
      8'h01: return 7'h0F;
      8'h02, 8'h03, 8'h04, 8'h05, 8'h06: return 7'(7'h01 << (s - 8'h02));
      8'h0A: return 7'h20;
      8'h0B: return 7'h40;
      default: return 7'h00;
    endcase
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] s, input logic [31:0] d);
    int n;
    n = 0;
    got.delete();
    exp.delete();
    foreach (pss_obj_table_inst.tbl[i])
      if (d == pss_pkg::SAVE_KEY && (pss_obj_table_inst.tbl[i].cat & msk(s)) != 0)
        exp.push_back(pss_obj_table_inst.tbl[i].index);
    @(negedge clk);
    wrValid <= 1;
    wrReq <= '{sub: s, data: d};
    @(negedge clk);
    wrValid <= 0;
    chk("busy start", msk(s) != 7'h00 && d == pss_pkg::SAVE_KEY, busy);
    @(negedge clk);
    // the master only trusts the save once busy drops and the subindex reads back 1
    while (busy === 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("busy end", 0, busy);
    rdSub <= s;
    repeat (2) @(negedge clk);
    chk("store count", exp.size(), got.size());
    foreach (exp[i]) chk("store index", exp[i], got[i]);
    chk("readback", msk(s) == 7'h00 ? 32'h00000000 : (d == pss_pkg::SAVE_KEY ? pss_pkg::DONE_VAL : d), rdData);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (storeValid && storeReady) got.push_back(storeIndex);
  end
  always @(negedge clk) begin
    rs = xs(rs);
    stall <= rs[0];
    if (cyc > 20000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    srst <= 0;
    chk("reset busy", 0, busy);
    chk("reset store", 0, storeValid);
    foreach (subs[i]) wr(subs[i], pss_pkg::SAVE_KEY);
    wr(8'h07, pss_pkg::SAVE_KEY);
    wr(8'h06, {1'b1, rs[30:0]});
    wr(8'h02, 32'h65766172);
    wr(8'h01, pss_pkg::SAVE_KEY);
    end_of_test();
  end
endmodule
